/* logic/nffi_defs.svh */
// Constants for the NAND frame flash host controller: command codes,
// address layout and timing counts derived from the 250 MHz system clock.
// Assumes it is included by bare name from the package and the modules.
`ifndef NFFI_DEFS_SVH
`define NFFI_DEFS_SVH

// ----------------------------------------------------------------------
// Command codes sent with command latch select high
// ----------------------------------------------------------------------
`define NFFI_CMD_READ      8'h00
`define NFFI_CMD_RESET     8'hff
`define NFFI_CMD_PROG      8'h80
`define NFFI_CMD_PROG_GO   8'h10
`define NFFI_CMD_ERASE     8'h60
`define NFFI_CMD_ERASE_GO  8'hd0
`define NFFI_CMD_STATUS    8'h70
`define NFFI_CMD_IDENT     8'h90

// ----------------------------------------------------------------------
// Address layout: column, frame, row and block fields
// ----------------------------------------------------------------------
`define NFFI_ADDR_W        19
`define NFFI_COL_LSB       0
`define NFFI_COL_MSB       4
`define NFFI_FRAME_LSB     5
`define NFFI_ROW_LSB       7
`define NFFI_BLOCK_LSB     12
`define NFFI_FRAME_BYTES   32
`define NFFI_ADDR_CYCLES   3
`define NFFI_IDENT_BYTES   2

// ----------------------------------------------------------------------
// Timing: times as printed, counts derived from the clock rate
// ----------------------------------------------------------------------
`define NFFI_CLK_MHZ       250
`define NFFI_T_RC_NS       120
`define NFFI_T_PWRUP_NS    1000
`define NFFI_T_SETTLE_NS   100
`define NFFI_RC_CYC        ((`NFFI_T_RC_NS * `NFFI_CLK_MHZ + 999) / 1000)
`define NFFI_HALF_CYC      ((`NFFI_RC_CYC + 1) / 2)
`define NFFI_PWRUP_CYC     ((`NFFI_T_PWRUP_NS * `NFFI_CLK_MHZ + 999) / 1000)
`define NFFI_SETTLE_CYC    ((`NFFI_T_SETTLE_NS * `NFFI_CLK_MHZ + 999) / 1000)

`endif

/* logic/nffi_pkg.sv */
// Types for the NAND frame flash host controller.
// Assumes nffi_defs.svh is on the include path.
`include "nffi_defs.svh"

package nffi_pkg;

  // ----------------------------------------------------------------------
  // Operations requested on the user side
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ   = 3'h0,
    OP_PROG   = 3'h1,
    OP_ERASE  = 3'h2,
    OP_STATUS = 3'h3,
    OP_IDENT  = 3'h4,
    OP_RESET  = 3'h5
  } nffi_op_type;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_PWRUP  = 4'h0,
    S_IDLE   = 4'h1,
    S_CMD1   = 4'h2,
    S_ADDR   = 4'h3,
    S_DATA   = 4'h4,
    S_CMD2   = 4'h5,
    S_SETTLE = 4'h6,
    S_WAIT   = 4'h7,
    S_READ   = 4'h8
  } nffi_state_type;

  // ----------------------------------------------------------------------
  // Whole register state of the controller
  // ----------------------------------------------------------------------
  typedef struct packed {
    nffi_state_type st;       // Sequencer state
    nffi_op_type    op;       // Operation in progress
    logic [18:0]    addr;     // Latched byte address
    logic [8:0]     cnt;      // Cycle counter within a bus cycle or wait
    logic [5:0]     idx;      // Index of the current byte
    logic [5:0]     last;     // Index of the final byte of this phase
    logic           ce_n;     // Chip select pin
    logic           cle;      // Command latch select pin
    logic           ale;      // Address latch select pin
    logic           we_n;     // Write strobe pin
    logic           re_n;     // Read strobe pin
    logic           oe;       // Port output enable
    logic [7:0]     dout;     // Byte driven onto the port
    logic           rd_valid; // Read byte pulse
    logic [7:0]     rd_data;  // Read byte
    logic           done;     // Operation finished pulse
    logic           rb_s1;    // Ready/busy synchroniser, first stage
    logic           rb_s2;    // Ready/busy synchroniser, second stage
    logic [7:0]     pt_s1;    // Port input synchroniser, first stage
    logic [7:0]     pt_s2;    // Port input synchroniser, second stage
  } nffi_regs_type;

endpackage : nffi_pkg

/* logic/nffi_frame_mem.sv */
// Frame staging memory: one write port, one read port with registered data.
// Assumes a single clock and that the writer never hits a slot being read.
`timescale 1ns/1ns

module nffi_frame_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // Clock
  input  wire logic             sys_clk_i,
  // Write port
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // Read port
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];   // Frame bytes

  // Write and registered read
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_q[rd_addr_i];
  end

endmodule : nffi_frame_mem

/* logic/nffi_host_ctrl.sv */
// Host controller driving a byte-wide NAND frame flash over its pins.
// Assumes the pins reach the device directly; the byte port is split into
// input, output and enable, and the wire is resolved outside.
`timescale 1ns/1ns
`include "nffi_defs.svh"

module nffi_host_ctrl #(
  parameter int HALF = `NFFI_HALF_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  // Command request
  input  wire logic        cmd_valid_i,
  input  wire logic [2:0]  cmd_op_i,
  input  wire logic [18:0] byte_address_bits_i,
  output logic             cmd_ready_o,
  output logic             busy_o,
  output logic             done_o,
  // Frame buffer load for program
  input  wire logic        buf_we_i,
  input  wire logic [4:0]  buf_addr_i,
  input  wire logic [7:0]  buf_data_i,
  // Read byte stream
  output logic             rd_valid_o,
  output logic [7:0]       rd_data_o,
  // Flash pins
  output logic             ce_n_o,
  output logic             cle_o,
  output logic             ale_o,
  output logic             we_n_o,
  output logic             read_strobe_n_o,
  output logic             wp_n_o,
  input  wire logic        ready_busy_i,
  input  wire logic [7:0]  shared_byte_port_i,
  output logic      [7:0]  shared_byte_port_o,
  output logic             shared_byte_port_oe_o
);

  // ----------------------------------------------------------------------
  // Constants and state
  // ----------------------------------------------------------------------
  localparam logic [8:0] HALF_C   = 9'(HALF);
  localparam logic [8:0] CYC_LAST = 9'(2 * HALF - 1);
  localparam logic [8:0] PWR_LAST = 9'(`NFFI_PWRUP_CYC - 1);
  localparam logic [8:0] SET_LAST = 9'(`NFFI_SETTLE_CYC - 1);
  localparam logic [5:0] FR_LAST  = 6'(`NFFI_FRAME_BYTES - 1);
  localparam logic [5:0] ID_LAST  = 6'(`NFFI_IDENT_BYTES - 1);
  localparam logic [5:0] AD_LAST  = 6'(`NFFI_ADDR_CYCLES - 1);

  nffi_pkg::nffi_regs_type q;        // Registered state
  nffi_pkg::nffi_regs_type d;        // Next state
  logic [7:0]              mem_rdata; // Staged program byte
  nffi_pkg::nffi_op_type   req_op;   // Requested operation

  assign req_op = nffi_pkg::nffi_op_type'(cmd_op_i);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Command byte that opens an operation
  function automatic logic [7:0] open_code(input nffi_pkg::nffi_op_type op);
    case (op)
      nffi_pkg::OP_READ:   open_code = `NFFI_CMD_READ;
      nffi_pkg::OP_PROG:   open_code = `NFFI_CMD_PROG;
      nffi_pkg::OP_ERASE:  open_code = `NFFI_CMD_ERASE;
      nffi_pkg::OP_STATUS: open_code = `NFFI_CMD_STATUS;
      nffi_pkg::OP_IDENT:  open_code = `NFFI_CMD_IDENT;
      default:             open_code = `NFFI_CMD_RESET;
    endcase
  endfunction : open_code

  // Address byte for cycle idx, top five bits of the last cycle zero
  function automatic logic [7:0] addr_byte(input logic [18:0] a, input logic [5:0] i);
    case (i)
      6'h00:   addr_byte = a[7:0];
      6'h01:   addr_byte = a[15:8];
      default: addr_byte = {5'h00, a[18:16]};
    endcase
  endfunction : addr_byte

  // Start a write strobe cycle with the given latch selects and byte
  function automatic nffi_pkg::nffi_regs_type begin_wr(
    input nffi_pkg::nffi_regs_type r, input nffi_pkg::nffi_state_type st,
    input logic cle, input logic ale, input logic [7:0] b,
    input logic [5:0] idx, input logic [5:0] last);
    nffi_pkg::nffi_regs_type n;
    n      = r;
    n.st   = st;
    n.cle  = cle;
    n.ale  = ale;
    n.dout = b;
    n.idx  = idx;
    n.last = last;
    n.cnt  = 9'h000;
    n.we_n = 1'b0;
    n.re_n = 1'b1;
    n.oe   = 1'b1;
    n.ce_n = 1'b0;
    begin_wr = n;
  endfunction : begin_wr

  // Start a read strobe cycle with the port released
  function automatic nffi_pkg::nffi_regs_type begin_rd(
    input nffi_pkg::nffi_regs_type r, input logic [5:0] idx, input logic [5:0] last);
    nffi_pkg::nffi_regs_type n;
    n      = r;
    n.st   = nffi_pkg::S_READ;
    n.cle  = 1'b0;
    n.ale  = 1'b0;
    n.oe   = 1'b0;
    n.idx  = idx;
    n.last = last;
    n.cnt  = 9'h000;
    n.we_n = 1'b1;
    n.re_n = 1'b0;
    n.ce_n = 1'b0;
    begin_rd = n;
  endfunction : begin_rd

  // Return to idle, deselect and release the port
  function automatic nffi_pkg::nffi_regs_type finish(input nffi_pkg::nffi_regs_type r);
    nffi_pkg::nffi_regs_type n;
    n      = r;
    n.st   = nffi_pkg::S_IDLE;
    n.ce_n = 1'b1;
    n.cle  = 1'b0;
    n.ale  = 1'b0;
    n.oe   = 1'b0;
    n.we_n = 1'b1;
    n.re_n = 1'b1;
    n.done = 1'b1;
    finish = n;
  endfunction : finish

  // Release all strobes and count out the busy settle time
  function automatic nffi_pkg::nffi_regs_type settle(input nffi_pkg::nffi_regs_type r);
    nffi_pkg::nffi_regs_type n;
    n      = r;
    n.st   = nffi_pkg::S_SETTLE;
    n.cle  = 1'b0;
    n.ale  = 1'b0;
    n.oe   = 1'b0;
    n.we_n = 1'b1;
    n.cnt  = 9'h000;
    settle = n;
  endfunction : settle

  // ----------------------------------------------------------------------
  // Frame staging memory
  // ----------------------------------------------------------------------
  nffi_frame_mem #(.WIDTH(8), .DEPTH(`NFFI_FRAME_BYTES), .AW(5)) u_mem (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (buf_we_i & ~busy_o),
    .wr_addr_i (buf_addr_i),
    .wr_data_i (buf_data_i),
    .rd_addr_i (q.idx[4:0]),
    .rd_data_o (mem_rdata)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Status and reset may go while the device is busy, others wait ready
  assign cmd_ready_o = (q.st == nffi_pkg::S_IDLE) &&
                       (q.rb_s2 || req_op == nffi_pkg::OP_STATUS ||
                        req_op == nffi_pkg::OP_RESET);

  // Next state of every register
  always_comb begin
    d          = q;
    d.rd_valid = 1'b0;
    d.done     = 1'b0;
    case (q.st)
      // Hold off every command after reset
      nffi_pkg::S_PWRUP: begin
        d.cnt = q.cnt + 9'h001;
        if (q.cnt == PWR_LAST) begin
          d.st  = nffi_pkg::S_IDLE;
          d.cnt = 9'h000;
        end
      end
      // Take a request and send its opening command
      nffi_pkg::S_IDLE: begin
        if (cmd_valid_i && cmd_ready_o) begin
          d      = begin_wr(q, nffi_pkg::S_CMD1, 1'b1, 1'b0, open_code(req_op), 6'h00,
                            6'h00);
          d.op   = req_op;
          d.done = 1'b0;    // A take right after done must not stretch the pulse
          d.addr = byte_address_bits_i;
          if (req_op == nffi_pkg::OP_PROG) begin
            d.addr[`NFFI_COL_MSB:`NFFI_COL_LSB] = 5'h00;
          end
          if (req_op == nffi_pkg::OP_IDENT) begin
            d.addr = 19'h00000;
          end
        end
      end
      // Write strobe cycles: strobe low first half, rising edge at midpoint
      nffi_pkg::S_CMD1, nffi_pkg::S_ADDR, nffi_pkg::S_DATA, nffi_pkg::S_CMD2: begin
        d.cnt  = q.cnt + 9'h001;
        d.we_n = (d.cnt >= HALF_C);
        if (q.st == nffi_pkg::S_DATA) begin
          d.dout = mem_rdata;
        end
        if (q.cnt == CYC_LAST) begin
          case (q.st)
            // After the opening command pick the next phase
            nffi_pkg::S_CMD1: begin
              case (q.op)
                nffi_pkg::OP_READ, nffi_pkg::OP_PROG:
                  d = begin_wr(q, nffi_pkg::S_ADDR, 1'b0, 1'b1, addr_byte(q.addr, 6'h00),
                               6'h00, AD_LAST);
                nffi_pkg::OP_ERASE:
                  d = begin_wr(q, nffi_pkg::S_ADDR, 1'b0, 1'b1, addr_byte(q.addr, 6'h01),
                               6'h01, AD_LAST);
                nffi_pkg::OP_IDENT:
                  d = begin_wr(q, nffi_pkg::S_ADDR, 1'b0, 1'b1, 8'h00, 6'h00, 6'h00);
                nffi_pkg::OP_STATUS:
                  d = begin_rd(q, 6'h00, 6'h00);
                default:
                  d = settle(q);
              endcase
            end
            // Exactly the address cycles the operation needs
            nffi_pkg::S_ADDR: begin
              if (q.idx != q.last) begin
                d = begin_wr(q, nffi_pkg::S_ADDR, 1'b0, 1'b1,
                             addr_byte(q.addr, q.idx + 6'h01), q.idx + 6'h01,
                             q.last);
              end else begin
                case (q.op)
                  nffi_pkg::OP_PROG:
                    d = begin_wr(q, nffi_pkg::S_DATA, 1'b0, 1'b0, mem_rdata, 6'h00, FR_LAST);
                  nffi_pkg::OP_ERASE:
                    d = begin_wr(q, nffi_pkg::S_CMD2, 1'b1, 1'b0, `NFFI_CMD_ERASE_GO,
                                 6'h00, 6'h00);
                  nffi_pkg::OP_IDENT:
                    d = begin_rd(q, 6'h00, ID_LAST);
                  default:
                    d = settle(q);
                endcase
              end
            end
            // Whole frame of program data, then the confirm command
            nffi_pkg::S_DATA: begin
              if (q.idx != q.last) begin
                d = begin_wr(q, nffi_pkg::S_DATA, 1'b0, 1'b0, mem_rdata, q.idx + 6'h01,
                             q.last);
              end else begin
                d = begin_wr(q, nffi_pkg::S_CMD2, 1'b1, 1'b0, `NFFI_CMD_PROG_GO,
                             6'h00, 6'h00);
              end
            end
            default: d = settle(q);
          endcase
        end
      end
      // Give ready/busy time to fall before trusting it
      nffi_pkg::S_SETTLE: begin
        d.cnt = q.cnt + 9'h001;
        if (q.cnt == SET_LAST) begin
          d.st = nffi_pkg::S_WAIT;
        end
      end
      // Wait for ready, then stream the frame from the column to its end for a read
      nffi_pkg::S_WAIT: begin
        if (q.rb_s2) begin
          if (q.op == nffi_pkg::OP_READ) begin
            d = begin_rd(q, 6'h00, FR_LAST - {1'b0, q.addr[`NFFI_COL_MSB:`NFFI_COL_LSB]});
          end else begin
            d = finish(q);
          end
        end
      end
      // Read strobe cycles: sample late in the low half
      nffi_pkg::S_READ: begin
        d.cnt  = q.cnt + 9'h001;
        d.re_n = (d.cnt >= HALF_C);
        if (q.cnt == HALF_C - 9'h001) begin
          d.rd_valid = 1'b1;
          d.rd_data  = q.pt_s2;
        end
        if (q.cnt == CYC_LAST) begin
          if (q.idx != q.last) begin
            d = begin_rd(q, q.idx + 6'h01, q.last);
          end else begin
            d = finish(q);
          end
        end
      end
      default: d.st = nffi_pkg::S_IDLE;
    endcase
    // Synchronisers always advance, even on a phase change that copies q
    d.rb_s1 = ready_busy_i;
    d.rb_s2 = q.rb_s1;
    d.pt_s1 = shared_byte_port_i;
    d.pt_s2 = q.pt_s1;
  end

  // Register the state, reset to the power-up wait
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      q      <= '0;
      q.st   <= nffi_pkg::S_PWRUP;
      q.ce_n <= 1'b1;
      q.we_n <= 1'b1;
      q.re_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign busy_o                = (q.st != nffi_pkg::S_IDLE);
  assign done_o                = q.done;
  assign rd_valid_o            = q.rd_valid;
  assign rd_data_o             = q.rd_data;
  assign ce_n_o                = q.ce_n;
  assign cle_o                 = q.cle;
  assign ale_o                 = q.ale;
  assign we_n_o                = q.we_n;
  assign read_strobe_n_o       = q.re_n;
  assign wp_n_o                = (q.st != nffi_pkg::S_PWRUP);
  assign shared_byte_port_o    = q.dout;
  assign shared_byte_port_oe_o = q.oe;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  int unsigned age_q;     // Cycles since reset, saturating
  int unsigned re_gap_q;  // Cycles since the last read strobe fall
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      age_q    <= 0;
      re_gap_q <= 1000;
    end else begin
      age_q    <= (age_q < 100000) ? age_q + 1 : age_q;
      re_gap_q <= (!q.re_n && d.re_n == 1'b0 && q.re_n == 1'b0) ? re_gap_q + 1 :
                  ((q.re_n && !d.re_n) ? 0 : re_gap_q + 1);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  property p_pwrup;
    $fell(we_n_o) |-> age_q >= `NFFI_PWRUP_CYC;
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("Strobe before power-up wait");

  property p_addr_top;
    (ale_o && $fell(we_n_o) && q.idx == 6'h02) |-> shared_byte_port_o[7:3] == 5'h00;
  endproperty
  a_addr_top: assert property (p_addr_top) else $error("Top address bits not zero");

  property p_rd_period;
    $fell(read_strobe_n_o) |-> $past(re_gap_q) + 1 >= `NFFI_RC_CYC;
  endproperty
  a_rd_period: assert property (p_rd_period) else $error("Read cycle too short");

  property p_port_dir;
    !read_strobe_n_o |-> !shared_byte_port_oe_o ##1 1'b1;
  endproperty
  a_port_dir: assert property (p_port_dir) else $error("Port driven during read");

  property p_cmd_code;
    (cle_o && $fell(we_n_o)) |-> (shared_byte_port_o inside {`NFFI_CMD_READ,
      `NFFI_CMD_RESET, `NFFI_CMD_PROG, `NFFI_CMD_PROG_GO, `NFFI_CMD_ERASE,
      `NFFI_CMD_ERASE_GO, `NFFI_CMD_STATUS, `NFFI_CMD_IDENT});
  endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("Undefined command byte");

  property p_wait_ready;
    (cmd_valid_i && cmd_ready_o && req_op != nffi_pkg::OP_STATUS &&
     req_op != nffi_pkg::OP_RESET) |-> q.rb_s2 ##1 (cle_o && !we_n_o);
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("Command while busy");

  c_read:  cover property (q.op == nffi_pkg::OP_READ && done_o);
  c_prog:  cover property (q.op == nffi_pkg::OP_PROG && done_o);
  c_erase: cover property (q.op == nffi_pkg::OP_ERASE && done_o);

endmodule : nffi_host_ctrl

/* verification/nffi_flash_model.sv */
// Behavioural flash device facing the host controller.
// Assumes strobes come straight from the host; the model has no clock.
`timescale 1ns/1ns
`include "nffi_defs.svh"
module nffi_flash_model #(
  parameter int         T_BUSY = 800,
  parameter logic [7:0] STAT   = 8'hc0,
  parameter logic [7:0] ID0    = 8'h3c,  // Arbitrary value
  parameter logic [7:0] ID1    = 8'h4d   // Arbitrary value
) (
  // Host pins
  input  wire logic       ce_n_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       we_n_i,
  input  wire logic       re_n_i,
  input  wire logic [7:0] port_i,
  // Device pins
  output logic      [7:0] port_o,
  output logic            rb_o
);
  logic [7:0]  arr [int];  // Absent cell reads as erased
  logic [7:0]  fr  [32];   // Data register
  logic [7:0]  cmd;
  logic [18:0] a;
  int          na;
  int          col;
  initial begin
    port_o = 8'h00;
    rb_o   = 1'b1;
  end
  // Busy low for a while, then ready
  task automatic go_busy();
    fork
      begin
        rb_o = 1'b0;
        #(T_BUSY) rb_o = 1'b1;
      end
    join_none
  endtask : go_busy
  // Latch on strobe rise; select high between bytes aborts nothing
  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i) begin
      cmd = port_i;
      na  = 0;
      col = 0;
      if (cmd == `NFFI_CMD_PROG_GO) begin
        for (int i = 0; i < 32; i++) arr[{a[18:5], 5'(i)}] = fr[i];
        go_busy();
      end
      if (cmd == `NFFI_CMD_ERASE_GO) begin
        for (int i = 0; i < 4096; i++) arr.delete({a[18:12], 12'(i)});
        go_busy();
      end
      if (cmd == `NFFI_CMD_RESET) go_busy();
    end else if (!ce_n_i && ale_i) begin
      if (cmd == `NFFI_CMD_ERASE && na == 0) na = 1;
      if (na == 0) a[7:0] = port_i;
      else if (na == 1) a[15:8] = port_i;
      else if (na == 2) a[18:16] = port_i[2:0];
      na = na + 1;  // Surplus cycles change nothing
      if (na == 3 && cmd == `NFFI_CMD_READ) begin
        foreach (fr[i]) fr[i] = arr.exists({a[18:5], 5'(i)}) ? arr[{a[18:5], 5'(i)}] : 8'hff;
        col = a[4:0];
        go_busy();
      end
    end else if (!ce_n_i && cmd == `NFFI_CMD_PROG) begin
      fr[col[4:0]] = port_i;
      col = col + 1;
    end
  end
  // Strobe fall drives the byte and steps the column
  always @(negedge re_n_i) begin
    if (!ce_n_i) begin
      port_o = (cmd == `NFFI_CMD_STATUS) ? STAT :
               (cmd == `NFFI_CMD_IDENT) ? (col[0] ? ID1 : ID0) : fr[col[4:0]];
      col = col + 1;
    end
  end
  // Released bus shows the inverse of the last byte
  always @(posedge re_n_i) port_o = ~port_o;
endmodule : nffi_flash_model

/* verification/tb.sv */
// Self-checking bench for the host controller against the device model.
// Assumes the design package and defines are compiled first.
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [2:0]  op;
    logic [18:0] ad;
    logic [7:0]  n;
    logic [1:0]  md;
  } nffi_tb_row_type;
  localparam logic [7:0] STAT = 8'hc0;
  localparam logic [7:0] ID0  = 8'h3c;
  localparam logic [7:0] ID1  = 8'h4d;
  logic        sys_clk_i, srst_i, cmd_valid_i, cmd_ready_o, busy_o, done_o, buf_we_i;
  logic        rd_valid_o, ce_n_o, cle_o, ale_o, we_n_o, re_n, rb, oe, re_q, wp_n;
  logic [2:0]  cmd_op_i;
  logic [18:0] byte_address_bits_i;
  logic [4:0]  buf_addr_i;
  logic [7:0]  buf_data_i, rd_data_o, port, host_o, mdl_o;
  logic [7:0]  got [$];
  int          bad_count = 0, n_compared = 0, cyc = 0, gap = 0;
  nffi_tb_row_type rows [10] = '{
    '{3'h2, 19'h01000, 8'd0, 2'h1}, '{3'h1, 19'h010a5, 8'd0, 2'h0},
    '{3'h0, 19'h010a0, 8'd32, 2'h0}, '{3'h0, 19'h010b3, 8'd13, 2'h0},
    '{3'h0, 19'h010bf, 8'd1, 2'h0}, '{3'h3, 19'h0, 8'd1, 2'h2},
    '{3'h4, 19'h0, 8'd2, 2'h3}, '{3'h2, 19'h01f00, 8'd0, 2'h1},
    '{3'h0, 19'h010a0, 8'd32, 2'h1}, '{3'h5, 19'h0, 8'd0, 2'h0}};
  assign port = oe ? host_o : mdl_o;
  nffi_host_ctrl dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .byte_address_bits_i(byte_address_bits_i),
    .cmd_ready_o(cmd_ready_o), .busy_o(busy_o), .done_o(done_o), .buf_we_i(buf_we_i),
    .buf_addr_i(buf_addr_i), .buf_data_i(buf_data_i), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .ce_n_o(ce_n_o), .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o),
    .read_strobe_n_o(re_n), .wp_n_o(wp_n), .ready_busy_i(rb), .shared_byte_port_i(port),
    .shared_byte_port_o(host_o), .shared_byte_port_oe_o(oe));
  nffi_flash_model #(.STAT(STAT), .ID0(ID0), .ID1(ID1)) mdl (.ce_n_i(ce_n_o), .cle_i(cle_o),
    .ale_i(ale_o), .we_n_i(we_n_o), .re_n_i(re_n), .port_i(port), .port_o(mdl_o), .rb_o(rb));
  task automatic tally_and_finish();
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  function automatic logic [7:0] ex(nffi_tb_row_type w, int k);
    case (w.md)
      2'h0: return 8'(7 * (int'(w.ad[4:0]) + k) + 3);
      2'h1: return 8'hff;
      2'h2: return STAT;
      default: return k[0] ? ID1 : ID0;
    endcase
  endfunction : ex
  // One whole request; collects streamed bytes until done
  task automatic run_op(input logic [2:0] op, input logic [18:0] ad);
    got.delete();
    do @(posedge sys_clk_i); while (cmd_ready_o !== 1'b1);
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    byte_address_bits_i <= ad;
    do @(posedge sys_clk_i); while (cmd_ready_o !== 1'b1);
    cmd_valid_i <= 1'b0;
    do begin
      @(posedge sys_clk_i);
      if (rd_valid_o === 1'b1) got.push_back(rd_data_o);
    end while (done_o !== 1'b1);
  endtask : run_op
  task automatic pwr_check();
    repeat (249) begin
      @(posedge sys_clk_i);
      chk(8'(cmd_ready_o), 8'h00);
      chk({6'h00, wp_n, busy_o}, 8'h01);
    end
  endtask : pwr_check
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // Strobe spacing monitor and hang guard
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    re_q <= re_n;
    gap <= (re_q && !re_n) ? 1 : gap + 1;
    if (re_q === 1'b1 && re_n === 1'b0) chk(8'(gap >= 30), 8'h01);
    if (cyc == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    {srst_i, cmd_valid_i, cmd_op_i, byte_address_bits_i, buf_we_i} = '1;
    {cmd_valid_i, buf_we_i, buf_addr_i, buf_data_i, re_q} = '0;
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    pwr_check();
    // Buffer writes are dropped while busy, so wait for the power-up wait to end
    do @(posedge sys_clk_i); while (busy_o !== 1'b0);
    chk(8'(wp_n), 8'h01);
    for (int i = 0; i < 32; i++) begin
      buf_we_i <= 1'b1;
      buf_addr_i <= 5'(i);
      buf_data_i <= 8'(7 * i + 3);
      @(posedge sys_clk_i);
    end
    buf_we_i <= 1'b0;
    foreach (rows[r]) begin
      run_op(rows[r].op, rows[r].ad);
      chk(8'(got.size()), rows[r].n);
      foreach (got[k]) chk(got[k], ex(rows[r], k));
    end
    // Reset in mid-read idles the pins and restarts the power-up wait
    cmd_valid_i <= 1'b1;
    cmd_op_i <= 3'h0;
    repeat (2) @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    repeat (300) @(posedge sys_clk_i);
    srst_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    chk(8'(ce_n_o), 8'h01);
    pwr_check();
    run_op(3'h3, 19'h0);
    chk(got[0], STAT);
    tally_and_finish();
  end
endmodule : tb
